//--- bridge_secondary_cfg_regs_tb.sv
// bridge_secondary_cfg_regs_tb: apb tests of the secondary config register bank
// assumes bscr_top, bscr_evt_model and one 250 mhz clock
`timescale 1ns/10ps
`default_nettype none
module bridge_secondary_cfg_regs_tb;
  import bscr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        forward_mode, wide_bus_strap, evt_discard, evt_unexpected, evt_overrun;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          num_checks = 0;

  bscr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .forward_mode, .wide_bus_strap, .evt_discard, .evt_unexpected,
    .evt_overrun, .irq);
  bscr_evt_model engine (.pclk, .evt_discard, .evt_unexpected, .evt_overrun);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until the rising edge that samples pready high; answer taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h0, "wait states");
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdchk

  // irq lags its cause by one cycle, so two edges settle it
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp}, "irq");
  endtask : irqchk

  // status bits in order {overrun, unexpected, discard, fast, wide}
  function automatic logic [31:0] cap(input logic [4:0] st);
    return {11'h0, st, BSCR_NEXT_CAP, BSCR_CAP_ID};
  endfunction : cap

  function automatic logic [31:0] cfg(input logic [7:0] pin, input logic [7:0] route);
    return {BSCR_ACCESS_IVL, BSCR_BURST_NEED, pin, route};
  endfunction : cfg

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {forward_mode, wide_bus_strap} = 2'h3;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(BSCR_OFF_SEC_CFG, cfg(BSCR_PIN_FWD, BSCR_ROUTE_RST), "cfg reset");
    chk({31'h0, er}, 32'h0, "mapped err");
    rdchk(BSCR_OFF_CAP, cap(5'h03), "cap reset");
    $display("test reset done");
    apb(1'b1, BSCR_OFF_SEC_CFG, 32'hFFFF_FFA5);
    rdchk(BSCR_OFF_SEC_CFG, cfg(BSCR_PIN_FWD, 8'hA5), "cfg write");
    @(posedge pclk) wide_bus_strap <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk(BSCR_OFF_CAP, cap(5'h02), "narrow strap");
    $display("test fields done");
    engine.pulse(3'h7);
    rdchk(BSCR_OFF_CAP, cap(5'h16), "forward events");
    irqchk(1'b0);
    apb(1'b1, BSCR_OFF_IRQ_MASK, 32'h7);
    rdchk(BSCR_OFF_IRQ_MASK, 32'h7, "mask");
    irqchk(1'b1);
    apb(1'b1, BSCR_OFF_CAP, 32'h0004_0000);
    rdchk(BSCR_OFF_CAP, cap(5'h12), "w1c discard");
    apb(1'b1, BSCR_OFF_CAP, 32'h0);
    rdchk(BSCR_OFF_CAP, cap(5'h12), "w0 keeps");
    apb(1'b1, BSCR_OFF_IRQ_STAT, 32'h4);
    rdchk(BSCR_OFF_IRQ_STAT, 32'h0, "w1c overrun");
    irqchk(1'b0);
    $display("test events done");
    @(posedge pclk);
    forward_mode   <= 1'b0;
    wide_bus_strap <= 1'b1;
    repeat (3) @(posedge pclk);
    engine.pulse(3'h7);
    rdchk(BSCR_OFF_CAP, cap(5'h18), "reverse events");
    rdchk(BSCR_OFF_SEC_CFG, cfg(BSCR_PIN_REV, 8'hA5), "reverse pin");
    irqchk(1'b1);
    apb(1'b1, BSCR_OFF_CAP, 32'h0010_0000);
    rdchk(BSCR_OFF_CAP, cap(5'h08), "w1c overrun cap");
    $display("test reverse done");
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1, "unmapped write err");
    rdchk(8'h40, 32'h0, "unmapped read");
    chk({31'h0, er}, 32'h1, "unmapped read err");
    $display("test unmapped done");
    summarize();
  end

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    summarize();
  end
endmodule : bridge_secondary_cfg_regs_tb
`default_nettype wire

//--- bscr_evt_model.sv
// bscr_evt_model: transaction-engine stand-in raising one-cycle event pulses
// assumes pclk from the bench; pulses launched right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module bscr_evt_model
(
  // clock
  input  wire logic pclk,
  // events
  output var  logic evt_discard,
  output var  logic evt_unexpected,
  output var  logic evt_overrun
);
  initial {evt_overrun, evt_unexpected, evt_discard} = 3'h0;
  // bits are {overrun, unexpected, discard}; held one cycle so each edge counts once
  task automatic pulse(input logic [2:0] which);
    @(posedge pclk);
    {evt_overrun, evt_unexpected, evt_discard} <= which;
    @(posedge pclk);
    {evt_overrun, evt_unexpected, evt_discard} <= 3'h0;
  endtask : pulse
endmodule : bscr_evt_model
`default_nettype wire

//--- bscr_flags.sv
// bscr_flags: sticky split-completion flags, write-one-to-clear
// assumes events are one-cycle pulses on pclk; set beats clear
`timescale 1ns/10ps
`default_nettype none
module bscr_flags
(
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // set and clear
  input  wire logic [bscr_pkg::BSCR_NUM_EVT-1:0] set_evt,
  input  wire logic [bscr_pkg::BSCR_NUM_EVT-1:0] clr_mask,
  input  wire logic [bscr_pkg::BSCR_NUM_EVT-1:0] allow,
  // state
  output var  logic [bscr_pkg::BSCR_NUM_EVT-1:0] flags
);
  import bscr_pkg::*;
  genvar i;
  generate
    for (i = 0; i < BSCR_NUM_EVT; i++)
    begin : g_flag
      logic flag_next;
      // set wins over a same-cycle clear; disallowed mode forces zero
      assign flag_next = allow[i] & (set_evt[i] | (flags[i] & ~clr_mask[i]));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flags[i] <= BSCR_FLAGS_RST[i];
        else
          flags[i] <= flag_next;
      end
    end
  endgenerate
endmodule : bscr_flags
`default_nettype wire

//--- bscr_pkg.sv
// bscr_pkg: constants for the secondary-side configuration register bank
// assumes an apb slave at 250 mhz; offsets are byte addresses
// Behaviour
// - rw interrupt route byte, resets zero
// - pin byte 01h forward, 00h reverse
// - burst need byte, read-only, zero
// - access interval byte, read-only, zero
// - capability id reads 07h
// - next capability link reads 90h
// - bit16 set forward with wide strap
// - bit17 set in forward mode only
// - bit18 discard flag, forward only
// - bit19 unexpected completion flag, reverse only
// - bit20 set on completion overrun
package bscr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] BSCR_OFF_SEC_CFG  = 8'h7C;
  localparam logic [7:0] BSCR_OFF_CAP      = 8'h80;
  localparam logic [7:0] BSCR_OFF_IRQ_STAT = 8'hA0;
  localparam logic [7:0] BSCR_OFF_IRQ_MASK = 8'hA4;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int         BSCR_BIT_WIDE     = 16;
  localparam int         BSCR_BIT_FAST     = 17;
  localparam int         BSCR_BIT_DISCARD  = 18;
  localparam int         BSCR_BIT_UNEXP    = 19;
  localparam int         BSCR_BIT_OVERRUN  = 20;
  localparam int         BSCR_NUM_EVT      = 3;
  localparam logic [7:0] BSCR_PIN_FWD      = 8'h01;
  localparam logic [7:0] BSCR_PIN_REV      = 8'h00;
  localparam logic [7:0] BSCR_CAP_ID       = 8'h07;
  localparam logic [7:0] BSCR_NEXT_CAP     = 8'h90;
  localparam logic [7:0] BSCR_ROUTE_RST    = 8'h00;
  localparam logic [7:0] BSCR_BURST_NEED   = 8'h00;
  localparam logic [7:0] BSCR_ACCESS_IVL   = 8'h00;
  localparam logic [2:0] BSCR_FLAGS_RST    = 3'h0;
  localparam logic [2:0] BSCR_MASK_RST     = 3'h0;
endpackage : bscr_pkg

//--- bscr_sync.sv
// bscr_sync: two-flop level synchroniser
// assumes pclk domain, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module bscr_sync
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level
  input  wire logic d,
  output var  logic q
);
  logic meta_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : bscr_sync
`default_nettype wire

//--- bscr_top.sv
// bscr_top: secondary-side configuration registers of a reversible bridge
// assumes apb master on pclk; mode and strap pins are asynchronous
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module bscr_top
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // straps
  input  wire logic        forward_mode,
  input  wire logic        wide_bus_strap,
  // events from transaction engines
  input  wire logic        evt_discard,
  input  wire logic        evt_unexpected,
  input  wire logic        evt_overrun,
  // interrupt
  output var  logic        irq
);
  import bscr_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic fwd_s;
  logic wide_s;
  bscr_sync u_sync_fwd
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (forward_mode),
    .q       (fwd_s)
  );
  bscr_sync u_sync_wide
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (wide_bus_strap),
    .q       (wide_s)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic        access;
  logic        wr;
  logic        hit_cfg;
  logic        hit_cap;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;
  logic        setup;
  logic        rd_setup;
  logic        wr_cfg;
  logic        wr_cap;
  logic        wr_stat;
  logic        wr_mask;
  // every transfer is answered right after its setup, so setup alone decides pready
  assign setup    = psel & ~penable;
  assign rd_setup = setup & ~pwrite;
  assign access   = psel & penable;
  assign hit_cfg  = paddr == BSCR_OFF_SEC_CFG;
  assign hit_cap  = paddr == BSCR_OFF_CAP;
  assign hit_stat = paddr == BSCR_OFF_IRQ_STAT;
  assign hit_mask = paddr == BSCR_OFF_IRQ_MASK;
  assign hit_any  = hit_cfg | hit_cap | hit_stat | hit_mask;
  // writes land only at the edge that also samples pready high
  assign wr       = access & pready & pwrite & hit_any;
  assign wr_cfg   = wr & hit_cfg;
  assign wr_cap   = wr & hit_cap;
  assign wr_stat  = wr & hit_stat;
  assign wr_mask  = wr & hit_mask;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  route_reg;
  logic [2:0]  mask_reg;
  logic [2:0]  flags;
  logic [2:0]  set_evt;
  logic [2:0]  allow;
  logic [2:0]  clr_cap;
  logic [2:0]  clr_stat;
  logic [2:0]  clr_mask;
  logic [2:0]  pend;

  // discard in forward, unexpected in reverse, overrun in both
  assign allow    = {1'b1, ~fwd_s, fwd_s};
  assign set_evt  = {evt_overrun, evt_unexpected, evt_discard};
  assign clr_cap  = wr_cap ? pwdata[BSCR_BIT_OVERRUN:BSCR_BIT_DISCARD] : 3'h0;
  assign clr_stat = wr_stat ? pwdata[2:0] : 3'h0;
  assign clr_mask = clr_cap | clr_stat;

  bscr_flags u_flags
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_evt  (set_evt),
    .clr_mask (clr_mask),
    .allow    (allow),
    .flags    (flags)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      route_reg <= BSCR_ROUTE_RST;
    else if (wr_cfg)
      route_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_reg <= BSCR_MASK_RST;
    else if (wr_mask)
      mask_reg <= pwdata[2:0];
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0]  pin_val;
  logic [15:0] stat_val;
  logic [31:0] cfg_word;
  logic [31:0] cap_word;
  logic [31:0] rd_next;
  assign pin_val  = fwd_s ? BSCR_PIN_FWD : BSCR_PIN_REV;
  assign stat_val = {11'h000, flags, fwd_s, fwd_s & wide_s};
  assign cfg_word = {BSCR_ACCESS_IVL, BSCR_BURST_NEED, pin_val, route_reg};
  assign cap_word = {stat_val, BSCR_NEXT_CAP, BSCR_CAP_ID};
  assign rd_next  = hit_cfg  ? cfg_word :
                    hit_cap  ? cap_word :
                    hit_stat ? {29'h0, flags} :
                    hit_mask ? {29'h0, mask_reg} : 32'h0;
  assign pend     = flags & mask_reg;

  // ----------------------------------------
  // response
  // ----------------------------------------
  logic        ready_next;
  logic        err_next;
  logic [31:0] rdata_next;
  // answer in the first access cycle; unmapped addresses give pslverr
  // prdata is zero outside a read answer so stale data never leaks
  assign ready_next = setup;
  assign err_next   = setup & ~hit_any;
  assign rdata_next = rd_setup ? rd_next : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= ready_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= err_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else
      prdata <= rdata_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |pend;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  a_ready_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("pready missing after setup");

  a_ready_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long");

  a_err_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup & !hit_any) |=> pslverr)
    else $error("pslverr missing on unmapped address");

  a_err_mapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup & hit_any) |=> !pslverr)
    else $error("pslverr on mapped address");

  a_err_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  a_rdata_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rd_setup |=> prdata == 32'h0)
    else $error("read data outside a read answer");

  a_rdata_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & !hit_any) |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // configuration fields, seen on the bus
  // ----------------------------------------
  a_route_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cfg |=> route_reg == $past(pwdata[7:0]))
    else $error("route byte not written");

  a_route_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_cfg |=> $stable(route_reg))
    else $error("route byte changed without write");

  a_route_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cfg) |=> prdata[7:0] == $past(route_reg))
    else $error("route byte read wrong");

  a_pin_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cfg) |=> prdata[15:8] == ($past(fwd_s) ? 8'h01 : 8'h00))
    else $error("pin byte wrong for mode");

  a_const_bytes: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cfg) |=> prdata[31:16] == 16'h0000)
    else $error("grant or latency nonzero");

  a_cap_header: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cap) |=> prdata[15:0] == 16'h9007)
    else $error("capability header wrong");

  a_wide_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cap) |=> prdata[16] == $past(fwd_s & wide_s))
    else $error("wide bit wrong");

  a_fast_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cap) |=> prdata[17] == $past(fwd_s))
    else $error("fast bit wrong");

  a_cap_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup & hit_cap) |=> prdata[31:18] == {11'h000, $past(flags)})
    else $error("status flags read wrong");

  // ----------------------------------------
  // split-completion flags
  // ----------------------------------------
  a_discard_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (evt_discard & fwd_s) |=> flags[0])
    else $error("discard flag not set");

  a_discard_rev: assert property (
    @(posedge pclk) disable iff (!presetn)
    !fwd_s |=> !flags[0])
    else $error("discard flag in reverse mode");

  a_unexp_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (evt_unexpected & !fwd_s) |=> flags[1])
    else $error("unexpected flag not set");

  a_unexp_fwd: assert property (
    @(posedge pclk) disable iff (!presetn)
    fwd_s |=> !flags[1])
    else $error("unexpected flag in forward mode");

  a_overrun_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    evt_overrun |=> flags[2])
    else $error("overrun flag not set");

  a_clear_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_cap & pwdata[BSCR_BIT_OVERRUN] & !evt_overrun) |=> !flags[2])
    else $error("overrun flag not cleared");

  a_clear_stat: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_stat & pwdata[2] & !evt_overrun) |=> !flags[2])
    else $error("overrun flag not cleared by status write");

  a_zero_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    (flags[2] & !clr_mask[2]) |=> flags[2])
    else $error("overrun flag lost without clear");

  a_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    (evt_overrun & clr_mask[2]) |=> flags[2])
    else $error("clear beat a same-cycle event");

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  a_mask_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_mask |=> mask_reg == $past(pwdata[2:0]))
    else $error("mask not written");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(flags) & $past(mask_reg)))
    else $error("irq level wrong");

  a_irq_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mask_reg == 3'h0) |=> !irq)
    else $error("irq with every source masked");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_cfg_read: cover property (@(posedge pclk) access & pready & !pwrite & hit_cfg);
  c_clear: cover property (@(posedge pclk) flags[2] ##1 wr & hit_cap ##1 !flags[2]);
  c_irq: cover property (@(posedge pclk) $rose(irq));
  c_unexp_rev: cover property (@(posedge pclk) $rose(flags[1]));
  c_unmapped: cover property (@(posedge pclk) pready & pslverr);
endmodule : bscr_top
`default_nettype wire
